// ===== dv/fmid_prog.sv
// Purpose: serial programmer model on the clocked and async link
// Assumes: link clock idles high, period 125 ns
// Notes:   receive line pulled up when not driven
`timescale 1ns/10ps
module fmid_prog (
	// Link pins
	output reg  sck,
	output reg  rxd,
	input  wire txd,
	input  wire busy
);
	// Idle levels between frames
	initial begin
		sck = 1'h1;
		rxd = 1'h1;
	end

	// Strap level; low means async, clock then held low
	task park(input lvl);
		sck = lvl;
	endtask

	// One byte each way; ok low if busy never drops
	task xfer(input [7:0] tx, output [7:0] rx, output ok);
		integer i;
		begin
			ok = 1'h0;
			for (i = 0; i < 4000 && !ok; i = i + 1) begin
				if (busy === 1'h0) ok = 1'h1;
				else #10;
			end
			for (i = 0; i < 8; i = i + 1) begin
				sck = 1'h0;
				rxd = tx[i];
				#62;
				rx[i] = txd;
				sck = 1'h1;
				#63;
			end
			rxd = 1'h1;
		end
	endtask

	// Async byte toward the device, 8N1 at the bench bit time of 160 ns
	task uart(input [7:0] b);
		integer k;
		begin
			for (k = 0; k < 10; k = k + 1) begin
				rxd = (k == 0) ? 1'h0 : (k == 9) ? 1'h1 : b[k-1];
				#160;
			end
		end
	endtask
endmodule // fmid_prog

// ===== dv/fmid_top_asserts.sv
// Purpose: port checker for fmid_top
// Assumes: one clock domain, reset active low
// Notes:   bound into every fmid_top instance
`timescale 1ns/10ps
`include "fmid_regs.vh"
module fmid_chk (
	// Clock and reset
	input wire        MCLK,
	input wire        RST_N,
	// Pins
	input wire        PROCESSOR_MODE_PIN,
	input wire        FLASH_MODE_SELECT_INPUT,
	input wire        TXD,
	input wire        BUSY,
	// Requests
	input wire        REQ_VALID,
	input wire        REQ_READY,
	input wire        REQ_ERASE,
	input wire [19:0] REQ_ADDR,
	input wire [7:0]  REQ_WDATA,
	input wire        REQ_REJECT,
	// Flash engine
	input wire        OP_START,
	input wire [19:0] OP_ADDR,
	input wire [19:0] OP_LEN,
	input wire [7:0]  OP_WDATA,
	input wire        OP_BUSY,
	// Status
	input wire        CMD_VALID,
	input wire        MODE_SERIAL,
	input wire        MODE_PARALLEL,
	input wire        SER_CLOCKED,
	input wire        ID_OPEN,
	input wire        ID_REFUSED
);
	// Request taken, and aimed at the boot window
	wire take = REQ_VALID && REQ_READY;
	wire boot = REQ_ADDR >= `FMID_BOOT_BASE;
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	one_answer_a: assert property (take |=> OP_START != REQ_REJECT)
		else $error("request not answered by one pulse");
	boot_erase_a: assert property (take && REQ_ERASE && boot && MODE_PARALLEL
		|=> OP_START && OP_ADDR == `FMID_BOOT_BASE && OP_LEN == `FMID_BOOT_SIZE)
		else $error("boot erase not whole area");
	prog_pass_a: assert property (take && !REQ_ERASE && MODE_PARALLEL |=> OP_START
		&& OP_ADDR == $past(REQ_ADDR) && OP_LEN == 20'h1 && OP_WDATA == $past(REQ_WDATA))
		else $error("program request not passed on");
	refuse_a: assert property (take && ID_REFUSED |=> REQ_REJECT && !OP_START)
		else $error("request served after ID miss");
	refuse_keep_a: assert property (ID_REFUSED |=> ID_REFUSED && !ID_OPEN && !CMD_VALID)
		else $error("refusal not kept");
	strap_a: assert property (MODE_SERIAL |-> PROCESSOR_MODE_PIN && !FLASH_MODE_SELECT_INPUT)
		else $error("serial mode with wrong straps");
	async_busy_a: assert property (MODE_SERIAL && !SER_CLOCKED |-> BUSY)
		else $error("async busy pin low");
	eng_busy_a: assert property (MODE_SERIAL && SER_CLOCKED && OP_BUSY
		&& $past(OP_BUSY) |-> BUSY)
		else $error("busy low during flash operation");
	par_idle_a: assert property (MODE_PARALLEL |-> !BUSY && TXD)
		else $error("serial pins active in parallel mode");

	// Main scenarios reached
	boot_c: cover property (OP_START && OP_LEN == `FMID_BOOT_SIZE);
	refuse_c: cover property ($rose(ID_REFUSED));
	cmd_c: cover property (CMD_VALID);
endmodule // fmid_chk

bind fmid_top fmid_chk u_chk (.*);

// ===== dv/fmid_top_bench.sv
// Purpose: self-checking bench of fmid_top
// Assumes: ID byte k stored as 30h+4k, engine busy 4 cycles
// Notes:   async mode runs at a bit time of 16 clock cycles
`timescale 1ns/10ps
`include "fmid_regs.vh"
module fmid_top_bench;
	reg         mclk, rst_n, pmode, fsel, cmd_ready, tx_valid, req_valid, req_erase, blank, ok;
	reg  [7:0]  tx_data, req_wdata, fl_data, rx;
	reg  [19:0] req_addr;
	reg  [2:0]  eng_cnt;
	reg  [68:0] rows [0:4];
	reg  [68:0] r;
	reg  [7:0]  q [$];
	wire        sck, rxd, txd, busy, cmd_valid, tx_ready, req_ready, req_reject, op_start;
	wire        mode_ser, mode_par, ser_clk, id_open, id_ref, op_erase;
	wire [4:0]  stat = {id_open, id_ref, mode_ser, req_ready, tx_ready};
	wire [19:0] fl_addr, op_addr, op_len;
	wire [7:0]  cmd_data, op_wdata;
	wire        op_busy = eng_cnt != 3'h0;
	wire [19:0] fl_off = fl_addr - `FMID_ID_BASE;
	integer     error_cnt, n_tests, i, j;

	fmid_top #(.BIT_CYC(16'h0010)) dut (
		.MCLK(mclk), .RST_N(rst_n), .PROCESSOR_MODE_PIN(pmode),
		.FLASH_MODE_SELECT_INPUT(fsel), .SERIAL_UNIT_CLOCK_PIN(sck), .RXD(rxd), .TXD(txd),
		.BUSY(busy), .FL_RD_ADDR(fl_addr), .FL_RD_DATA(fl_data), .CMD_VALID(cmd_valid),
		.CMD_READY(cmd_ready), .CMD_DATA(cmd_data), .TX_VALID(tx_valid), .TX_READY(tx_ready),
		.TX_DATA(tx_data), .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_ERASE(req_erase),
		.REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .REQ_REJECT(req_reject),
		.OP_START(op_start), .OP_ERASE(op_erase), .OP_ADDR(op_addr), .OP_LEN(op_len),
		.OP_WDATA(op_wdata), .OP_BUSY(op_busy), .MODE_SERIAL(mode_ser),
		.MODE_PARALLEL(mode_par), .SER_CLOCKED(ser_clk), .ID_OPEN(id_open), .ID_REFUSED(id_ref)
	);
	fmid_prog prog (.sck(sck), .rxd(rxd), .txd(txd), .busy(busy));

	// Clock, 100 MHz
	initial begin
		mclk = 1'h0;
		forever #5 mclk = ~mclk;
	end

	// Flash cells: all ff when blank, else ID bytes at base plus 4k, zero elsewhere
	always @* begin
		fl_data = 8'h00;
		if (blank)
			fl_data = 8'hff;
		else if (fl_off[1:0] == 2'h0 && fl_off <= 20'h18)
			fl_data = 8'h30 + fl_off[7:0];
	end

	// Engine raises busy the cycle after a start
	always @(posedge mclk) begin
		if (op_start)
			eng_cnt <= 3'h4;
		else if (op_busy)
			eng_cnt <= eng_cnt - 3'h1;
	end

	// Collect command bytes handed on
	always @(posedge mclk) begin
		if (cmd_valid && cmd_ready)
			q.push_back(cmd_data);
	end

	task test_done;
		begin
			$display("Checks %0d mismatches %0d", n_tests, error_cnt);
			if (error_cnt == 0 && n_tests > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask

	task check(input string nm, input [19:0] e, input [19:0] g);
		begin
			n_tests = n_tests + 1;
			if (g !== e) begin
				error_cnt = error_cnt + 1;
				$display("Error %s expected %h seen %h", nm, e, g);
			end
		end
	endtask

	// Bounded wait at falling edges for one status level
	task wait_hi(input [2:0] k);
		begin
			for (j = 0; j < 3000 && stat[4-k] !== 1'h1; j = j + 1)
				@(negedge mclk);
			if (j == 3000) begin
				check("wait", 1'h1, 1'h0);
				test_done;
			end
		end
	endtask

	// Strap, hold reset long enough, release
	task reset_dut(input p, input f, input s);
		begin
			@(negedge mclk);
			rst_n = 1'h0;
			pmode = p;
			fsel = f;
			prog.park(s);
			q.delete();
			repeat (20) @(negedge mclk);
			check("TXD reset", 1'h1, txd);
			rst_n = 1'h1;
		end
	endtask

	// Request held until taken, outputs seen one cycle later
	task req(input e, input [19:0] a, input [7:0] d);
		begin
			@(negedge mclk);
			req_valid = 1'h1;
			req_erase = e;
			req_addr = a;
			req_wdata = d;
			wait_hi(3);
			@(negedge mclk);
			req_valid = 1'h0;
		end
	endtask

	task send(input [7:0] b);
		begin
			prog.xfer(b, rx, ok);
			if (!ok) begin
				check("link busy", 1'h1, 1'h0);
				test_done;
			end
		end
	endtask

	task id_frame(input [7:0] last);
		begin
			send(8'hf5);
			for (i = 0; i < 4; i = i + 1)
				send(8'h00);
			for (i = 0; i < 6; i = i + 1)
				send(8'h30 + 8'h4 * i[7:0]);
			send(last);
		end
	endtask

	initial begin
		{rst_n, pmode, fsel, tx_valid, req_valid, req_erase, blank} = 7'h0;
		{tx_data, req_wdata, req_addr, eng_cnt} = 39'h0;
		cmd_ready = 1'h1;
		error_cnt = 0;
		n_tests = 0;
		rows[0] = {1'h0, 20'h10000, 20'h10000, 20'h00001, 8'h5a};
		rows[1] = {1'h1, 20'h10000, 20'h10000, 20'h00000, 8'h00};
		rows[2] = {1'h1, 20'hff123, 20'hfe000, 20'h02000, 8'h00};
		rows[3] = {1'h0, 20'hfe010, 20'hfe010, 20'h00001, 8'ha5};
		rows[4] = {1'h1, 20'hfe000, 20'hfe000, 20'h02000, 8'h00};
		// Parallel mode request rows
		reset_dut(1'h1, 1'h1, 1'h1);
		for (i = 0; i < 5; i = i + 1) begin
			r = rows[i];
			req(r[68], r[67:48], r[7:0]);
			check("OP_START", 1'h1, op_start);
			check("OP_ERASE", r[68], op_erase);
			check("OP_ADDR", r[47:28], op_addr);
			check("OP_LEN", r[27:8], op_len);
			if (!r[68]) check("OP_WDATA", r[7:0], op_wdata);
		end
		check("MODE_PARALLEL", 1'h1, mode_par);
		$display("Parallel rows done");
		// Clocked serial, wrong last ID byte
		reset_dut(1'h1, 1'h0, 1'h1);
		wait_hi(2);
		check("SER_CLOCKED", 1'h1, ser_clk);
		id_frame(8'h49);
		wait_hi(1);
		send(8'h2c);
		req(1'h0, 20'h20000, 8'h11);
		check("REQ_REJECT", 1'h1, req_reject);
		check("CMD count", 20'h0, q.size());
		$display("Refused ID done");
		// Matching ID, full buffer, transmit, requests
		reset_dut(1'h1, 1'h0, 1'h1);
		wait_hi(2);
		id_frame(8'h48);
		wait_hi(0);
		cmd_ready = 1'h0;
		send(8'h2c);
		send(8'h71);
		repeat (30) @(negedge mclk);
		check("BUSY full", 1'h1, busy);
		cmd_ready = 1'h1;
		repeat (6) @(negedge mclk);
		check("CMD first", 8'h2c, q[0]);
		check("CMD second", 8'h71, q[1]);
		tx_data = 8'h96;
		tx_valid = 1'h1;
		wait_hi(4);
		@(negedge mclk);
		tx_valid = 1'h0;
		send(8'h00);
		check("TXD byte", 8'h96, rx);
		req(1'h0, 20'hfe100, 8'h11);
		check("boot REJECT", 1'h1, req_reject);
		req(1'h0, 20'h20000, 8'h3c);
		check("user OP_LEN", 20'h1, op_len);
		$display("Open ID done");
		// Blank flash opens at once; async strap keeps busy up
		blank = 1'h1;
		reset_dut(1'h1, 1'h0, 1'h1);
		wait_hi(2);
		check("ID_OPEN blank", 1'h1, id_open);
		reset_dut(1'h1, 1'h0, 1'h0);
		wait_hi(2);
		check("SER_CLOCKED", 1'h0, ser_clk);
		check("BUSY async", 1'h1, busy);
		prog.uart(8'h5c);
		repeat (4) @(negedge mclk);
		check("CMD async", 8'h5c, q[0]);
		@(negedge mclk);
		tx_data = 8'ha3;
		tx_valid = 1'h1;
		@(negedge mclk);
		tx_valid = 1'h0;
		repeat (8) @(negedge mclk);
		for (i = 0; i < 10; i = i + 1) begin
			check("TXD async", (i == 0) ? 1'h0 : (i == 9) ? 1'h1 : tx_data[i-1], txd);
			repeat (16) @(negedge mclk);
		end
		$display("Blank and async done");
		test_done;
	end
endmodule // fmid_top_bench

// ===== hdl/fmid_buf2.v
// Purpose: two-entry valid/ready buffer on the received byte path
// Assumes: single clock, asynchronous active-low reset
// Notes:   head data comes straight from a register
`timescale 1ns/10ps
module fmid_buf2 #(
	parameter W = 8
) (
	// Clock and reset
	input  wire         clk,
	input  wire         rst_n,
	// Fill side
	input  wire         in_valid,
	output wire         in_ready,
	input  wire [W-1:0] in_data,
	// Drain side
	output wire         out_valid,
	input  wire         out_ready,
	output wire [W-1:0] out_data
);
	reg [W-1:0] d0_ff;
	reg [W-1:0] d1_ff;
	reg [1:0]   cnt_ff;
	wire        push;
	wire        pop;

	// Honest full and empty from the occupancy count
	assign in_ready  = (cnt_ff != 2'h2);
	assign out_valid = (cnt_ff != 2'h0);
	assign out_data  = d0_ff;
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Entry 0 is always the head; entry 1 slides down on a pop
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			d0_ff  <= {W{1'b0}};
			d1_ff  <= {W{1'b0}};
			cnt_ff <= 2'h0;
		end else begin
			if (pop) begin
				d0_ff <= (cnt_ff == 2'h2) ? d1_ff : in_data;
				if (cnt_ff == 2'h2 && push)
					d1_ff <= in_data;
			end else if (push) begin
				if (cnt_ff == 2'h0)
					d0_ff <= in_data;
				else
					d1_ff <= in_data;
			end
			if (push && !pop)
				cnt_ff <= cnt_ff + 2'h1;
			else if (pop && !push)
				cnt_ff <= cnt_ff - 2'h1;
			else if (pop && push && cnt_ff == 2'h1)
				cnt_ff <= 2'h1;
		end
	end
endmodule // fmid_buf2

// ===== hdl/fmid_regs.vh
// Purpose: shared constants of the flash rewrite entry and ID check block
// Assumes: 20-bit flash byte addresses, byte-wide flash reads
// Notes:   definitions only
`ifndef FMID_REGS_VH
`define FMID_REGS_VH

// Flash address width and erased cell value
`define FMID_AW          20
`define FMID_ERASED      8'hff

// Stored ID code: first byte at the base, one byte per step
`define FMID_ID_BASE     20'hfffdf
`define FMID_ID_STEP     20'h00004
`define FMID_ID_LAST_IX  3'h6

// ID check frame: command, three address bytes, size, then the ID bytes
`define FMID_CMD_IDCHK   8'hf5
`define FMID_ID_HDR      4'h5
`define FMID_ID_LAST     4'hb

// Boot area window and size
`define FMID_BOOT_BASE   20'hfe000
`define FMID_BOOT_LAST   20'hfffff
`define FMID_BOOT_SIZE   20'h02000

// Operation lengths handed to the flash engine
`define FMID_PROG_LEN    20'h00001
`define FMID_BLK_LEN     20'h00000

// Serial framing
`define FMID_BITS        4'h8
`define FMID_STOP_CNT    4'ha
`define FMID_TX_FRAME    4'ha

// Pin synchroniser settling before straps are caught, and the scan check point after the flash read lag
`define FMID_STRAP_WAIT  2'h2
`define FMID_SCAN_CHK    2'h2

`endif

// ===== hdl/fmid_top.v
// Purpose: rewrite mode entry, serial link and ID check in front of the flash
// Assumes: flash read data valid one cycle after FL_RD_ADDR changes
// Notes:   async bit time is a parameter; serial link pins are synchronised
`timescale 1ns/10ps
`include "fmid_regs.vh"

module fmid_top #(
	parameter [15:0] BIT_CYC = 16'h0364
) (
	// Clock and reset
	input  wire                 MCLK,
	input  wire                 RST_N,
	// Mode select pins
	input  wire                 PROCESSOR_MODE_PIN,
	input  wire                 FLASH_MODE_SELECT_INPUT,
	// Serial link pins
	input  wire                 SERIAL_UNIT_CLOCK_PIN,
	input  wire                 RXD,
	output wire                 TXD,
	output wire                 BUSY,
	// Flash read port
	output wire [`FMID_AW-1:0]  FL_RD_ADDR,
	input  wire [7:0]           FL_RD_DATA,
	// Received command bytes
	output wire                 CMD_VALID,
	input  wire                 CMD_READY,
	output wire [7:0]           CMD_DATA,
	// Bytes to transmit
	input  wire                 TX_VALID,
	output wire                 TX_READY,
	input  wire [7:0]           TX_DATA,
	// Program and erase requests
	input  wire                 REQ_VALID,
	output wire                 REQ_READY,
	input  wire                 REQ_ERASE,
	input  wire [`FMID_AW-1:0]  REQ_ADDR,
	input  wire [7:0]           REQ_WDATA,
	output wire                 REQ_REJECT,
	// Flash engine
	output wire                 OP_START,
	output wire                 OP_ERASE,
	output wire [`FMID_AW-1:0]  OP_ADDR,
	output wire [`FMID_AW-1:0]  OP_LEN,
	output wire [7:0]           OP_WDATA,
	input  wire                 OP_BUSY,
	// Status
	output wire                 MODE_SERIAL,
	output wire                 MODE_PARALLEL,
	output wire                 SER_CLOCKED,
	output wire                 ID_OPEN,
	output wire                 ID_REFUSED
);
	localparam [2:0] ST_STRAP = 3'h0;
	localparam [2:0] ST_SCAN  = 3'h1;
	localparam [2:0] ST_SER   = 3'h2;
	localparam [2:0] ST_PAR   = 3'h3;
	localparam [2:0] ST_OFF   = 3'h4;

	reg                ps_s1_ff, ps_s2_ff, fm_s1_ff, fm_s2_ff;
	reg                ck_s1_ff, ck_s2_ff, ck_s3_ff, rx_s1_ff, rx_s2_ff;
	reg  [2:0]         st_ff;
	reg  [1:0]         wait_ff;
	reg                clocked_ff;
	reg  [2:0]         scan_ix_ff;
	reg                open_ff, refused_ff, miss_ff;
	reg  [3:0]         frm_ff;
	reg  [`FMID_AW-1:0] rd_addr_ff;
	reg  [7:0]         rx_sh_ff;
	reg  [3:0]         rx_cnt_ff;
	reg  [15:0]        rx_tm_ff;
	reg                rx_done_ff;
	reg  [9:0]         tx_sh_ff;
	reg  [3:0]         tx_cnt_ff;
	reg  [15:0]        tx_tm_ff;
	reg                tx_full_ff;
	reg  [7:0]         tx_hold_ff;
	reg                busy_ff;
	reg                rej_ff, start_ff, erase_ff;
	reg  [`FMID_AW-1:0] op_addr_ff, op_len_ff;
	reg  [7:0]         op_wd_ff;
	wire               ck_rise, ck_fall, ser, buf_rdy, buf_push, req_take, req_boot;
	wire [2:0]         rd_ix;
	wire [3:0]         frm_ix;

	// Stored ID byte address from its index
	function [`FMID_AW-1:0] id_addr;
		input [2:0] ix;
		begin
			id_addr = `FMID_ID_BASE + (`FMID_ID_STEP * {17'h00000, ix});
		end
	endfunction

	// Boot window decode
	function in_boot;
		input [`FMID_AW-1:0] a;
		begin
			in_boot = (a >= `FMID_BOOT_BASE) && (a <= `FMID_BOOT_LAST);
		end
	endfunction

	// Pin synchronisers; the second stage is read, and the link clock also uses a third stage for edge detection
	always @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			{ps_s1_ff, ps_s2_ff, fm_s1_ff, fm_s2_ff} <= 4'h0;
			{ck_s1_ff, ck_s2_ff, ck_s3_ff} <= 3'h0;
			{rx_s1_ff, rx_s2_ff} <= 2'h3;
		end else begin
			ps_s1_ff <= PROCESSOR_MODE_PIN;
			ps_s2_ff <= ps_s1_ff;
			fm_s1_ff <= FLASH_MODE_SELECT_INPUT;
			fm_s2_ff <= fm_s1_ff;
			ck_s1_ff <= SERIAL_UNIT_CLOCK_PIN;
			ck_s2_ff <= ck_s1_ff;
			ck_s3_ff <= ck_s2_ff;
			rx_s1_ff <= RXD;
			rx_s2_ff <= rx_s1_ff;
		end
	end

	assign ck_rise = ck_s2_ff & ~ck_s3_ff;
	assign ck_fall = ~ck_s2_ff & ck_s3_ff;
	assign ser     = (st_ff == ST_SER);

	// Reads during the scan walk the ID row, later they follow the frame
	assign frm_ix = frm_ff - `FMID_ID_HDR;
	assign rd_ix  = (st_ff == ST_SCAN) ? scan_ix_ff :
	                (frm_ff >= `FMID_ID_HDR) ? frm_ix[2:0] : 3'h0;

	// Mode entry, blank scan and ID frame check
	always @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			st_ff      <= ST_STRAP;
			wait_ff    <= 2'h0;
			clocked_ff <= 1'b0;
			scan_ix_ff <= 3'h0;
			open_ff    <= 1'b0;
			refused_ff <= 1'b0;
			miss_ff    <= 1'b0;
			frm_ff     <= 4'h0;
			rd_addr_ff <= `FMID_ID_BASE;
		end else begin
			rd_addr_ff <= id_addr(rd_ix);
			case (st_ff)
			ST_STRAP: begin
				// Straps are caught once the synchronisers hold pin levels
				if (wait_ff == `FMID_STRAP_WAIT) begin
					wait_ff    <= 2'h0;
					clocked_ff <= ck_s2_ff;
					if (ps_s2_ff && !fm_s2_ff)
						st_ff <= ST_SCAN;
					else if (ps_s2_ff)
						st_ff <= ST_PAR;
					else
						st_ff <= ST_OFF;
				end else
					wait_ff <= wait_ff + 2'h1;
			end
			ST_SCAN: begin
				// Data lag two cycles behind the index, so check on the third
				if (wait_ff == `FMID_SCAN_CHK) begin
					wait_ff <= 2'h0;
					if (FL_RD_DATA != `FMID_ERASED)
						miss_ff <= 1'b1;
					if (scan_ix_ff == `FMID_ID_LAST_IX) begin
						open_ff <= ~miss_ff & (FL_RD_DATA == `FMID_ERASED);
						miss_ff <= 1'b0;
						st_ff   <= ST_SER;
					end else
						scan_ix_ff <= scan_ix_ff + 3'h1;
				end else
					wait_ff <= wait_ff + 2'h1;
			end
			ST_SER: begin
				if (rx_done_ff && !open_ff && !refused_ff) begin
					if (frm_ff == 4'h0) begin
						if (rx_sh_ff == `FMID_CMD_IDCHK)
							frm_ff <= 4'h1;
					end else if (frm_ff < `FMID_ID_HDR)
						frm_ff <= frm_ff + 4'h1;
					else if (frm_ff == `FMID_ID_LAST) begin
						frm_ff  <= 4'h0;
						miss_ff <= 1'b0;
						if (miss_ff || rx_sh_ff != FL_RD_DATA)
							refused_ff <= 1'b1;
						else
							open_ff <= 1'b1;
					end else begin
						frm_ff <= frm_ff + 4'h1;
						if (rx_sh_ff != FL_RD_DATA)
							miss_ff <= 1'b1;
					end
				end
			end
			ST_PAR: st_ff <= ST_PAR;
			default: st_ff <= ST_OFF;
			endcase
		end
	end

	// Receiver: clocked mode on link rising edges, async mode by bit timer
	always @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			rx_sh_ff   <= 8'h00;
			rx_cnt_ff  <= 4'h0;
			rx_tm_ff   <= 16'h0000;
			rx_done_ff <= 1'b0;
		end else begin
			rx_done_ff <= 1'b0;
			if (!ser)
				rx_cnt_ff <= 4'h0;
			else if (clocked_ff) begin
				if (ck_rise) begin
					rx_sh_ff <= {rx_s2_ff, rx_sh_ff[7:1]};
					if (rx_cnt_ff == `FMID_BITS - 4'h1) begin
						rx_cnt_ff  <= 4'h0;
						rx_done_ff <= 1'b1;
					end else
						rx_cnt_ff <= rx_cnt_ff + 4'h1;
				end
			end else if (rx_cnt_ff == 4'h0) begin
				if (!rx_s2_ff) begin
					rx_cnt_ff <= 4'h1;
					rx_tm_ff  <= BIT_CYC >> 1;
				end
			end else if (rx_tm_ff != 16'h0000)
				rx_tm_ff <= rx_tm_ff - 16'h0001;
			else begin
				rx_tm_ff <= BIT_CYC - 16'h0001;
				if (rx_cnt_ff == 4'h1 && rx_s2_ff)
					rx_cnt_ff <= 4'h0; // Start glitch, back to idle
				else if (rx_cnt_ff == `FMID_STOP_CNT) begin
					rx_cnt_ff  <= 4'h0;
					rx_done_ff <= rx_s2_ff; // Framing error drops the byte
				end else begin
					if (rx_cnt_ff != 4'h1)
						rx_sh_ff <= {rx_s2_ff, rx_sh_ff[7:1]};
					rx_cnt_ff <= rx_cnt_ff + 4'h1;
				end
			end
		end
	end

	// Only bytes after a passed check or on a blank part reach the command side
	assign buf_push = rx_done_ff & open_ff & ~refused_ff & ser;

	fmid_buf2 #(
		.W         (8)
	) u_buf (
		.clk       (MCLK),
		.rst_n     (RST_N),
		.in_valid  (buf_push),
		.in_ready  (buf_rdy),
		.in_data   (rx_sh_ff),
		.out_valid (CMD_VALID),
		.out_ready (CMD_READY),
		.out_data  (CMD_DATA)
	);

	assign TX_READY = ser & ~tx_full_ff;

	// Transmitter: clocked mode shifts on falling edges, async sends 8N1
	always @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			tx_sh_ff   <= 10'h3ff;
			tx_cnt_ff  <= 4'h0;
			tx_tm_ff   <= 16'h0000;
			tx_full_ff <= 1'b0;
			tx_hold_ff <= 8'h00;
		end else begin
			if (TX_VALID && TX_READY) begin
				tx_full_ff <= 1'b1;
				tx_hold_ff <= TX_DATA;
			end
			if (!ser)
				tx_sh_ff <= 10'h3ff;
			else if (clocked_ff) begin
				// The fall after a byte's last rise presents the next bit 0
				if (ck_fall && rx_cnt_ff == 4'h0) begin
					tx_sh_ff   <= {2'h3, tx_full_ff ? tx_hold_ff : `FMID_ERASED};
					tx_full_ff <= TX_VALID & TX_READY;
				end else if (ck_fall)
					tx_sh_ff <= {1'b1, tx_sh_ff[9:1]};
			end else if (tx_cnt_ff == 4'h0) begin
				if (tx_full_ff) begin
					tx_sh_ff   <= {1'b1, tx_hold_ff, 1'b0};
					tx_cnt_ff  <= `FMID_TX_FRAME;
					tx_tm_ff   <= BIT_CYC - 16'h0001;
					tx_full_ff <= 1'b0;
				end
			end else if (tx_tm_ff != 16'h0000)
				tx_tm_ff <= tx_tm_ff - 16'h0001;
			else begin
				tx_tm_ff  <= BIT_CYC - 16'h0001;
				tx_sh_ff  <= {1'b1, tx_sh_ff[9:1]};
				tx_cnt_ff <= tx_cnt_ff - 4'h1;
			end
		end
	end

	assign TXD = tx_sh_ff[0];

	// Busy: in clocked mode a full buffer stalls the programmer, so no byte is lost; async mode holds busy high
	// A pending transmit byte does not hold busy: in clocked mode only the programmer's clock can send it
	always @(posedge MCLK or negedge RST_N) begin
		if (!RST_N)
			busy_ff <= 1'b0;
		else if (st_ff == ST_SCAN)
			busy_ff <= 1'b1;
		else if (!ser)
			busy_ff <= 1'b0;
		else if (clocked_ff)
			busy_ff <= (rx_cnt_ff != 4'h0) | ~buf_rdy | OP_BUSY | start_ff;
		else
			busy_ff <= 1'b1;
	end

	assign BUSY = busy_ff;

	// Requests are held off while the engine runs or was just started
	assign REQ_READY = (ser | (st_ff == ST_PAR)) & ~OP_BUSY & ~start_ff;
	assign req_take  = REQ_VALID & REQ_READY;
	assign req_boot  = in_boot(REQ_ADDR);

	// Program and erase dispatch; serial mode never touches the boot area
	always @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			rej_ff     <= 1'b0;
			start_ff   <= 1'b0;
			erase_ff   <= 1'b0;
			op_addr_ff <= {`FMID_AW{1'b0}};
			op_len_ff  <= {`FMID_AW{1'b0}};
			op_wd_ff   <= 8'h00;
		end else begin
			rej_ff   <= 1'b0;
			start_ff <= 1'b0;
			if (req_take) begin
				if (ser && (req_boot || !open_ff || refused_ff))
					rej_ff <= 1'b1;
				else begin
					start_ff <= 1'b1;
					erase_ff <= REQ_ERASE;
					op_wd_ff <= REQ_WDATA;
					// Boot erase is clamped to the window base
					op_addr_ff <= (REQ_ERASE && req_boot) ? `FMID_BOOT_BASE : REQ_ADDR;
					if (!REQ_ERASE)
						op_len_ff <= `FMID_PROG_LEN;
					else if (req_boot)
						op_len_ff <= `FMID_BOOT_SIZE;
					else
						op_len_ff <= `FMID_BLK_LEN;
				end
			end
		end
	end

	assign REQ_REJECT    = rej_ff;
	assign OP_START      = start_ff;
	assign OP_ERASE      = erase_ff;
	assign OP_ADDR       = op_addr_ff;
	assign OP_LEN        = op_len_ff;
	assign OP_WDATA      = op_wd_ff;
	assign FL_RD_ADDR    = rd_addr_ff;
	assign MODE_SERIAL   = ser;
	assign MODE_PARALLEL = (st_ff == ST_PAR);
	assign SER_CLOCKED   = clocked_ff;
	assign ID_OPEN       = open_ff;
	assign ID_REFUSED    = refused_ff;
endmodule // fmid_top
